/* phrh_map.svh */
// Register offsets, field positions, codes and reset values of the PD hub request handler.
`ifndef PHRH_MAP_SVH
`define PHRH_MAP_SVH
`define PHRH_OFF_CTRL 6'h00
`define PHRH_OFF_SETUP 6'h04
`define PHRH_OFF_LENGTH 6'h08
`define PHRH_OFF_STATUS 6'h0C
`define PHRH_OFF_PDO_STAGE 6'h10
`define PHRH_OFF_TX_VDM 6'h14
`define PHRH_OFF_RESP 6'h18
`define PHRH_OFF_CHANGE 6'h1C
`define PHRH_OFF_CAP 6'h20
`define PHRH_CTRL_INTRUSIVE 0
`define PHRH_CTRL_RESET 1'h0
`define PHRH_CAP_RESET 20'hFFFFF
`define PHRH_KIND_FEATURE 8'h01
`define PHRH_KIND_SET_PORT_OBJECTS_REQ 8'h02
`define PHRH_KIND_GET_VENDOR_MSG_REQ 8'h03
`define PHRH_KIND_SEND_VENDOR_MSG_REQ 8'h04
`define PHRH_SEL_LAST 16'h0006
`define PHRH_SOP_LAST 16'h0002
`define PHRH_NPORTS 4
`define PHRH_PORT_MAX 8'h04
`define PHRH_MAX_PDO 3'h7
`define PHRH_MAX_PDO_N 7
`define PHRH_FIFO_DEPTH 8
`define PHRH_VDM_LEN 16'h0004
`define PHRH_CUR_LSB 0
`define PHRH_CUR_MSB 9
`define PHRH_VOLT_LSB 10
`define PHRH_VOLT_MSB 19
`endif

/* phrh_pkg.sv */
// Types shared by the PD hub request handler.
package phrh_pkg;
  // Handler sequencing states.
  typedef enum logic [1:0] {
    PHRH_IDLE = 2'b00,
    PHRH_ISSUE = 2'b01
  } phrh_state_e;
  // One bus word or power data object.
  typedef logic [31:0] phrh_word_t;
endpackage

/* phrh_request_handler.sv */
// Port request handler of a PD capable hub, reached over Avalon-MM.
//
// Overview of operation
// - Intrusive mode answers partner Requests with Wait.
// - Power role swap selector starts swap.
// - Go-to-minimum on provider port sends GotoMin.
// - Give-back on provider port returns borrowed power.
// - Accept selector accepts partner's pending request.
// - Reject selector rejects partner's pending request.
// - Hard reset, then set port change flag.
// - Cable reset, then set port change flag.
// - Bad selector, port, role or length errors.
// - Stored objects trigger updated source capabilities.
// - Objects beyond hub capability are rejected.
// - Objects advertised in supplied order.
// - Invalid objects for port give error.
// - Object request checks value, port, length.
// - Each get returns at most one message.
// - Received messages returned oldest first.
// - Empty queue answers with zero length.
// - Send destination 0, 1 or 2 only.
// - Feature requests valid only in intrusive mode.
// - Unsatisfiable feature requests report an error.
`timescale 1ns/1ps
`default_nettype none
`include "phrh_map.svh"

module phrh_request_handler
  import phrh_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM register slave.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Port state from the protocol engine.
  input wire logic [3:0] port_provider,
  // Partner Request arrival and Wait answer.
  input wire logic rx_request,
  input wire logic [1:0] rx_request_port,
  output logic wait_tx_valid,
  output logic [1:0] wait_tx_port,
  // Feature command toward the protocol engine.
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [1:0] cmd_port,
  input wire logic cmd_ready,
  // Reset completion from the protocol engine.
  input wire logic reset_done,
  input wire logic [1:0] reset_done_port,
  // Source capabilities update.
  output logic src_cap_valid,
  output logic [1:0] src_cap_port,
  output logic [2:0] src_cap_count,
  // Stored object read port.
  input wire logic [1:0] obj_rd_port,
  input wire logic [2:0] obj_rd_idx,
  output logic [31:0] obj_rd_data,
  // Received vendor messages.
  input wire logic rx_vdm_valid,
  input wire logic [1:0] rx_vdm_port,
  input wire logic [31:0] rx_vdm_word,
  // Vendor message transmit.
  output logic vdm_tx_valid,
  output logic [31:0] vdm_tx_word,
  output logic [1:0] vdm_tx_sop,
  output logic [1:0] vdm_tx_port,
  input wire logic vdm_tx_ready
);

  logic intrusive; // Policy mode: high means intrusive.
  logic [15:0] req_len; // Data length of the next request.
  logic [19:0] cap; // Hub capability limit for objects.
  phrh_word_t tx_word; // Vendor message staged for sending.
  phrh_word_t resp_word; // Message fetched by the last get.
  logic [7:0] resp_len; // Byte length of the last answer.
  logic busy; // A command waits on the engine.
  logic done; // Last request finished.
  logic err; // Last request ended in a Request Error.
  logic [3:0] change; // Per-port PD change flags.
  logic [2:0] stage_cnt; // Objects staged so far.
  phrh_word_t stage [`PHRH_MAX_PDO_N]; // Staged objects.
  phrh_word_t pdo_mem [`PHRH_NPORTS][`PHRH_MAX_PDO_N]; // Stored objects.
  phrh_word_t vdm_mem [`PHRH_NPORTS][`PHRH_FIFO_DEPTH]; // Received messages.
  logic [3:0] wr_ptr [`PHRH_NPORTS]; // FIFO write pointers.
  logic [3:0] rd_ptr [`PHRH_NPORTS]; // FIFO read pointers.
  phrh_state_e state; // Sequencer state.

  // Bus handshake decode; a transfer completes when waitrequest is low.
  logic acc;
  logic wr_en;
  assign acc = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_en = avs_write & ~avs_waitrequest & (avs_byteenable == 4'hF);

  logic setup_wr;
  assign setup_wr = wr_en & (avs_address == `PHRH_OFF_SETUP);

  // Fields of the setup word being written.
  logic [7:0] kind;
  logic [7:0] port;
  logic [15:0] value;
  logic [7:0] port_m1;
  logic [1:0] pidx;
  logic port_ok;
  assign kind = avs_writedata[7:0];
  assign port = avs_writedata[15:8];
  assign value = avs_writedata[31:16];
  assign port_m1 = port - 8'h01;
  assign pidx = port_m1[1:0];
  assign port_ok = (port != 8'h00) && (port <= `PHRH_PORT_MAX);

  // FIFO state of the addressed port.
  logic [3:0] fill;
  logic fifo_empty;
  assign fill = wr_ptr[pidx] - rd_ptr[pidx];
  assign fifo_empty = (fill == 4'h0);

  // Object checks: zero voltage is invalid, above the limit exceeds it.
  logic pdo_bad;
  always_comb begin
    pdo_bad = 1'b0;
    for (int i = 0; i < `PHRH_MAX_PDO_N; i++) begin
      if (3'(i) < stage_cnt) begin
        if (stage[i][`PHRH_VOLT_MSB:`PHRH_VOLT_LSB] == 10'h000) begin
          pdo_bad = 1'b1;
        end
        if ((stage[i][`PHRH_VOLT_MSB:`PHRH_VOLT_LSB] > cap[`PHRH_VOLT_MSB:`PHRH_VOLT_LSB]) ||
            (stage[i][`PHRH_CUR_MSB:`PHRH_CUR_LSB] > cap[`PHRH_CUR_MSB:`PHRH_CUR_LSB])) begin
          pdo_bad = 1'b1;
        end
      end
    end
  end

  // Request decode: the error verdict and the accepted actions.
  logic bad;
  logic do_feat;
  logic do_pdo;
  logic do_get;
  logic do_send;
  always_comb begin
    bad = 1'b1;
    do_feat = 1'b0;
    do_pdo = 1'b0;
    do_get = 1'b0;
    do_send = 1'b0;
    unique case (kind)
      `PHRH_KIND_FEATURE: begin
        // Non-intrusive mode is answered with an error rather than left undefined.
        bad = ~intrusive | ~port_ok | (value > `PHRH_SEL_LAST) | (req_len != 16'h0000) |
              ~port_provider[pidx];
        do_feat = ~bad;
      end
      `PHRH_KIND_SET_PORT_OBJECTS_REQ: begin
        bad = (value != 16'h0000) | ~port_ok | (req_len == 16'h0000) |
              (req_len != {11'h000, stage_cnt, 2'b00}) | pdo_bad |
              ~port_provider[pidx];
        do_pdo = ~bad;
      end
      `PHRH_KIND_GET_VENDOR_MSG_REQ: begin
        bad = (value != 16'h0000) | ~port_ok | (req_len == 16'h0000) |
              (req_len[1:0] != 2'b00);
        do_get = ~bad;
      end
      `PHRH_KIND_SEND_VENDOR_MSG_REQ: begin
        bad = (value > `PHRH_SOP_LAST) | ~port_ok | (req_len != `PHRH_VDM_LEN);
        do_send = ~bad;
      end
      default: begin
        bad = 1'b1;
      end
    endcase
  end

  logic take;
  assign take = setup_wr & ~busy;

  // Wait states: drop waitrequest for one cycle per transfer, read data ready with it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read | avs_write) & avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read mux; unmapped offsets read as zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      unique case (avs_address)
        `PHRH_OFF_CTRL: avs_readdata <= {31'h0, intrusive};
        `PHRH_OFF_LENGTH: avs_readdata <= {16'h0000, req_len};
        `PHRH_OFF_STATUS: avs_readdata <= {13'h0, stage_cnt, resp_len, 5'h00, err, done, busy};
        `PHRH_OFF_TX_VDM: avs_readdata <= tx_word;
        `PHRH_OFF_RESP: avs_readdata <= resp_word;
        `PHRH_OFF_CHANGE: avs_readdata <= {28'h0, change};
        `PHRH_OFF_CAP: avs_readdata <= {12'h000, cap};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Software configuration registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intrusive <= `PHRH_CTRL_RESET;
      req_len <= 16'h0000;
      cap <= `PHRH_CAP_RESET;
      tx_word <= 32'h0000_0000;
    end else if (wr_en) begin
      if (avs_address == `PHRH_OFF_CTRL) begin
        intrusive <= avs_writedata[`PHRH_CTRL_INTRUSIVE];
      end
      if (avs_address == `PHRH_OFF_LENGTH) begin
        req_len <= avs_writedata[15:0];
      end
      if (avs_address == `PHRH_OFF_CAP) begin
        cap <= avs_writedata[19:0];
      end
      if (avs_address == `PHRH_OFF_TX_VDM) begin
        tx_word <= avs_writedata;
      end
    end
  end

  // Object staging; an object request always empties the stage, pass or fail.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_cnt <= 3'h0;
    end else if (take && (kind == `PHRH_KIND_SET_PORT_OBJECTS_REQ)) begin
      stage_cnt <= 3'h0;
    end else if (wr_en && (avs_address == `PHRH_OFF_PDO_STAGE) &&
                 (stage_cnt != `PHRH_MAX_PDO)) begin
      stage[stage_cnt] <= avs_writedata;
      stage_cnt <= stage_cnt + 3'h1;
    end
  end

  // Commit staged objects to the port in the order they were supplied.
  always_ff @(posedge clk) begin
    if (take & do_pdo) begin
      for (int i = 0; i < `PHRH_MAX_PDO_N; i++) begin
        pdo_mem[pidx][i] <= stage[i];
      end
    end
  end

  // Engine read port for advertised objects.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      obj_rd_data <= 32'h0000_0000;
    end else begin
      obj_rd_data <= pdo_mem[obj_rd_port][obj_rd_idx];
    end
  end

  // Capabilities update pulse after a successful object request.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_cap_valid <= 1'b0;
      src_cap_port <= 2'h0;
      src_cap_count <= 3'h0;
    end else begin
      src_cap_valid <= take & do_pdo;
      if (take & do_pdo) begin
        src_cap_port <= pidx;
        src_cap_count <= stage_cnt;
      end
    end
  end

  // Received message FIFOs; a message arriving at a full queue is dropped.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < `PHRH_NPORTS; p++) begin
        wr_ptr[p] <= 4'h0;
      end
    end else if (rx_vdm_valid &&
                 ((wr_ptr[rx_vdm_port] - rd_ptr[rx_vdm_port]) != 4'h8)) begin
      vdm_mem[rx_vdm_port][wr_ptr[rx_vdm_port][2:0]] <= rx_vdm_word;
      wr_ptr[rx_vdm_port] <= wr_ptr[rx_vdm_port] + 4'h1;
    end
  end

  // Get: one message per answer, oldest first, zero length when empty.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < `PHRH_NPORTS; p++) begin
        rd_ptr[p] <= 4'h0;
      end
      resp_word <= 32'h0000_0000;
      resp_len <= 8'h00;
    end else if (take) begin
      resp_len <= 8'h00;
      if (do_get && !fifo_empty) begin
        resp_word <= vdm_mem[pidx][rd_ptr[pidx][2:0]];
        resp_len <= 8'h04;
        rd_ptr[pidx] <= rd_ptr[pidx] + 4'h1;
      end
    end
  end

  // Sequencer: feature and send commands hold valid until the engine takes them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= PHRH_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_code <= 3'h0;
      cmd_port <= 2'h0;
      vdm_tx_valid <= 1'b0;
      vdm_tx_word <= 32'h0000_0000;
      vdm_tx_sop <= 2'h0;
      vdm_tx_port <= 2'h0;
    end else begin
      unique case (state)
        PHRH_IDLE: begin
          if (take) begin
            err <= bad;
            done <= bad | do_pdo | do_get;
            if (do_feat) begin
              // Swap, minimum, give-back, accept, reject and both resets go out here.
              cmd_valid <= 1'b1;
              cmd_code <= value[2:0];
              cmd_port <= pidx;
              busy <= 1'b1;
              state <= PHRH_ISSUE;
            end
            if (do_send) begin
              vdm_tx_valid <= 1'b1;
              vdm_tx_word <= tx_word;
              vdm_tx_sop <= value[1:0];
              vdm_tx_port <= pidx;
              busy <= 1'b1;
              state <= PHRH_ISSUE;
            end
          end
        end
        PHRH_ISSUE: begin
          if (cmd_valid & cmd_ready) begin
            cmd_valid <= 1'b0;
          end
          if (vdm_tx_valid & vdm_tx_ready) begin
            vdm_tx_valid <= 1'b0;
          end
          if ((cmd_valid & cmd_ready) | (vdm_tx_valid & vdm_tx_ready)) begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= PHRH_IDLE;
          end
        end
      endcase
    end
  end

  // Change flags: reset completion sets, write-one clears, and the set wins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      change <= 4'h0;
    end else begin
      for (int p = 0; p < `PHRH_NPORTS; p++) begin
        if (reset_done && (reset_done_port == 2'(p))) begin
          change[p] <= 1'b1;
        end else if (wr_en && (avs_address == `PHRH_OFF_CHANGE) && avs_writedata[p]) begin
          change[p] <= 1'b0;
        end
      end
    end
  end

  // Partner Requests are held off with Wait while intrusive.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_tx_valid <= 1'b0;
      wait_tx_port <= 2'h0;
    end else begin
      wait_tx_valid <= rx_request & intrusive;
      if (rx_request) begin
        wait_tx_port <= rx_request_port;
      end
    end
  end

endmodule // phrh_request_handler
`default_nettype wire

/* phrh_engine_model.sv */
// Behavioural protocol engine facing the PD hub request handler.
`timescale 1ns/1ps
`default_nettype none
module phrh_engine_model (
  // Clock, reset and pacing.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  // Offers from the handler.
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [1:0] cmd_port,
  output logic cmd_ready,
  input wire logic vdm_tx_valid,
  input wire logic [31:0] vdm_tx_word,
  input wire logic [1:0] vdm_tx_sop,
  input wire logic [1:0] vdm_tx_port,
  output logic vdm_tx_ready,
  // Reset completion.
  output logic reset_done,
  output logic [1:0] reset_done_port,
  // Last offer taken.
  output logic [2:0] last_code,
  output logic [1:0] last_port,
  output logic [31:0] last_word,
  output logic [1:0] last_sop
);
  logic [2:0] age; // Cycles the current offer has waited.
  logic go; // Offer old enough to take.
  assign go = age >= (slow ? 3'h3 : 3'h0);
  // A slow engine lets an offer wait, so hold-until-ready is exercised.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age <= 3'h0;
      cmd_ready <= 1'b0;
      vdm_tx_ready <= 1'b0;
      reset_done <= 1'b0;
      reset_done_port <= 2'h0;
    end else begin
      age <= (cmd_valid || vdm_tx_valid) && !go ? age + 3'h1 : 3'h0;
      cmd_ready <= cmd_valid && !cmd_ready && go;
      vdm_tx_ready <= vdm_tx_valid && !vdm_tx_ready && go;
      reset_done <= cmd_valid && cmd_ready && cmd_code >= 3'h5;
      // The port lines carry garbage outside the completion pulse.
      reset_done_port <= cmd_valid && cmd_ready ? cmd_port : ~reset_done_port;
    end
  end
  // Keep what was taken for the bench to judge.
  always_ff @(posedge clk) begin
    if (cmd_valid && cmd_ready) begin
      last_code <= cmd_code;
      last_port <= cmd_port;
    end
    if (vdm_tx_valid && vdm_tx_ready) begin
      last_word <= vdm_tx_word;
      last_sop <= vdm_tx_sop;
      last_port <= vdm_tx_port;
    end
  end
endmodule // phrh_engine_model
`default_nettype wire

/* phrh_request_handler_assertions.sv */
// Port-level assertions for the PD hub request handler.
`timescale 1ns/1ps
`default_nettype none
module phrh_request_handler_assertions
  import phrh_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register bus.
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Engine side.
  input wire logic [3:0] port_provider,
  input wire logic rx_request,
  input wire logic [1:0] rx_request_port,
  input wire logic wait_tx_valid,
  input wire logic [1:0] wait_tx_port,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [1:0] cmd_port,
  input wire logic cmd_ready,
  input wire logic src_cap_valid,
  input wire logic [2:0] src_cap_count,
  input wire logic vdm_tx_valid,
  input wire logic [31:0] vdm_tx_word,
  input wire logic [1:0] vdm_tx_sop,
  input wire logic vdm_tx_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // A request seen while the slave still waits.
  sequence bus_req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // One cycle of answer, then waiting again.
  sequence bus_ans_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  bus_timing_a: assert property (bus_req_s |=> bus_ans_s)
    else $error("bus answer timing wrong");
  wait_answer_a: assert property (wait_tx_valid |->
    $past(rx_request) && wait_tx_port == $past(rx_request_port))
    else $error("wait sent without a request");
  cmd_hold_a: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_code) && $stable(cmd_port))
    else $error("command changed before taken");
  cmd_single_a: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
    else $error("command offered twice");
  cmd_role_a: assert property (cmd_valid |->
    port_provider[cmd_port] && cmd_code <= 3'h6)
    else $error("command on bad port or selector");
  vdm_hold_a: assert property (vdm_tx_valid && !vdm_tx_ready |=>
    vdm_tx_valid && $stable(vdm_tx_word) && $stable(vdm_tx_sop))
    else $error("vendor message changed before taken");
  sop_range_a: assert property (vdm_tx_valid |-> vdm_tx_sop <= 2'h2)
    else $error("destination out of range");
  cap_pulse_a: assert property (src_cap_valid |->
    src_cap_count != 3'h0 ##1 !src_cap_valid)
    else $error("capability update malformed");
endmodule // phrh_request_handler_assertions
bind phrh_request_handler phrh_request_handler_assertions i_chk (
  .clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .port_provider,
  .rx_request, .rx_request_port, .wait_tx_valid, .wait_tx_port, .cmd_valid,
  .cmd_code, .cmd_port, .cmd_ready, .src_cap_valid, .src_cap_count,
  .vdm_tx_valid, .vdm_tx_word, .vdm_tx_sop, .vdm_tx_ready
);
`default_nettype wire

/* phrh_request_handler_test.sv */
// Self-checking bench for the PD hub request handler.
`timescale 1ns/1ps
`default_nettype none
`include "phrh_map.svh"
module phrh_request_handler_test
  import phrh_pkg::*;
;
  localparam phrh_word_t OBJ_A = 32'h0001912C; // 100 volt steps, 300 current.
  localparam phrh_word_t OBJ_B = 32'h0003C096; // 240 volt steps, 150 current.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  phrh_word_t avs_writedata = 32'h0;
  logic [3:0] port_provider = 4'h5; // Ports 1 and 3 act as provider.
  logic rx_request = 1'b0;
  logic [1:0] rx_request_port = 2'h0;
  logic [1:0] obj_rd_port = 2'h0;
  logic [2:0] obj_rd_idx = 3'h0;
  logic rx_vdm_valid = 1'b0;
  logic [1:0] rx_vdm_port = 2'h0;
  phrh_word_t rx_vdm_word = 32'h0;
  logic slow = 1'b0;
  logic avs_waitrequest, wait_tx_valid, cmd_valid, cmd_ready, reset_done;
  logic src_cap_valid, vdm_tx_valid, vdm_tx_ready;
  logic [2:0] cmd_code, src_cap_count, last_code, cap_cnt;
  logic [1:0] wait_tx_port, cmd_port, reset_done_port, src_cap_port;
  logic [1:0] vdm_tx_sop, vdm_tx_port, last_port, last_sop, wait_port, cap_port;
  phrh_word_t avs_readdata, obj_rd_data, vdm_tx_word, last_word, rd;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int waits = 0;
  int caps = 0;
  phrh_request_handler i_dut (.clk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .port_provider, .rx_request, .rx_request_port,
    .wait_tx_valid, .wait_tx_port, .cmd_valid, .cmd_code, .cmd_port,
    .cmd_ready, .reset_done, .reset_done_port, .src_cap_valid, .src_cap_port,
    .src_cap_count, .obj_rd_port, .obj_rd_idx, .obj_rd_data, .rx_vdm_valid,
    .rx_vdm_port, .rx_vdm_word, .vdm_tx_valid, .vdm_tx_word, .vdm_tx_sop,
    .vdm_tx_port, .vdm_tx_ready);
  phrh_engine_model i_eng (.clk, .rst_n, .slow, .cmd_valid, .cmd_code,
    .cmd_port, .cmd_ready, .vdm_tx_valid, .vdm_tx_word, .vdm_tx_sop,
    .vdm_tx_port, .vdm_tx_ready, .reset_done, .reset_done_port, .last_code,
    .last_port, .last_word, .last_sop);
  always #5 clk = ~clk;
  // Count the one-cycle pulses; a hang is cut short by the cycle ceiling.
  always @(posedge clk) begin
    if (wait_tx_valid === 1'b1) begin
      waits <= waits + 1;
      wait_port <= wait_tx_port;
    end
    if (src_cap_valid === 1'b1) begin
      caps <= caps + 1;
      cap_port <= src_cap_port;
      cap_cnt <= src_cap_count;
    end
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end
  task automatic complete_run;
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input phrh_word_t s, input phrh_word_t e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // One Avalon transfer; read data lands in rd at the answering edge.
  task automatic bus(input logic w, input logic [5:0] a, input phrh_word_t d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Issue one request, poll until done, judge the error bit.
  task automatic req(input logic [7:0] k, p, input logic [15:0] v, l, input logic e);
    bus(1'b1, `PHRH_OFF_LENGTH, {16'h0, l});
    bus(1'b1, `PHRH_OFF_SETUP, {v, p, k});
    do bus(1'b0, `PHRH_OFF_STATUS, 32'h0); while (rd[1:0] !== 2'b10);
    chk("error", {31'h0, rd[2]}, {31'h0, e});
  endtask
  task automatic t_reset;
    bus(1'b0, `PHRH_OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0);
    bus(1'b0, `PHRH_OFF_CAP, 32'h0);
    chk("cap", rd, {12'h0, `PHRH_CAP_RESET});
    bus(1'b1, 6'h3C, 32'hFFFFFFFF);
    bus(1'b0, 6'h3C, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask
  // Partner Requests get a Wait only in intrusive mode.
  task automatic t_mode(input logic m);
    bus(1'b1, `PHRH_OFF_CTRL, {31'h0, m});
    rx_request <= 1'b1;
    rx_request_port <= 2'h2;
    @(posedge clk);
    rx_request <= 1'b0;
    repeat (3) @(posedge clk);
    chk("waits", waits, {31'h0, m});
    if (m) chk("wait port", wait_port, 2'h2);
    if (!m) req(8'h1, 8'h1, 16'h0, 16'h0, 1'b1);
  endtask
  task automatic t_feature;
    for (int s = 0; s < 7; s++) begin
      slow <= s[0];
      req(8'h1, 8'h1, 16'(s), 16'h0, 1'b0);
      chk("code", last_code, s);
      chk("port", last_port, 2'h0);
      bus(1'b0, `PHRH_OFF_CHANGE, 32'h0);
      chk("change", rd[3:0], {3'h0, s > 4});
      bus(1'b1, `PHRH_OFF_CHANGE, 32'hF);
    end
    req(8'h1, 8'h1, 16'h7, 16'h0, 1'b1);
    req(8'h1, 8'h0, 16'h0, 16'h0, 1'b1);
    req(8'h1, 8'h5, 16'h0, 16'h0, 1'b1);
    req(8'h1, 8'h1, 16'h0, 16'h4, 1'b1);
    req(8'h1, 8'h2, 16'h1, 16'h0, 1'b1);
  endtask
  task automatic t_objects;
    bus(1'b1, `PHRH_OFF_PDO_STAGE, OBJ_A);
    bus(1'b1, `PHRH_OFF_PDO_STAGE, OBJ_B);
    req(8'h2, 8'h1, 16'h0, 16'h8, 1'b0);
    chk("cap pulses", caps, 1);
    chk("cap count", {cap_port, cap_cnt}, 5'h02);
    obj_rd_idx <= 3'h1;
    repeat (2) @(posedge clk);
    chk("second object", obj_rd_data, OBJ_B);
    obj_rd_idx <= 3'h0;
    repeat (2) @(posedge clk);
    chk("first object", obj_rd_data, OBJ_A);
    bus(1'b1, `PHRH_OFF_CAP, 32'h000321F4);
    bus(1'b1, `PHRH_OFF_PDO_STAGE, OBJ_A);
    bus(1'b1, `PHRH_OFF_PDO_STAGE, OBJ_B);
    req(8'h2, 8'h1, 16'h0, 16'h8, 1'b1);
    bus(1'b1, `PHRH_OFF_PDO_STAGE, OBJ_A);
    req(8'h2, 8'h1, 16'h1, 16'h4, 1'b1);
    // Zero voltage stays inside the limit, so only the validity check can refuse it.
    bus(1'b1, `PHRH_OFF_PDO_STAGE, 32'h0000012C);
    req(8'h2, 8'h1, 16'h0, 16'h4, 1'b1);
    chk("cap pulses", caps, 1);
  endtask
  // Two messages arrive on port 2, then come back one per request.
  task automatic t_get;
    for (int i = 0; i < 3; i++) begin
      rx_vdm_valid <= i < 2;
      rx_vdm_port <= 2'h1;
      rx_vdm_word <= 32'hC0DE0000 + i;
      @(posedge clk);
    end
    for (int i = 0; i < 3; i++) begin
      req(8'h3, 8'h2, 16'h0, 16'h4, 1'b0);
      chk("answer length", rd[15:8], i < 2 ? 4 : 0);
      bus(1'b0, `PHRH_OFF_RESP, 32'h0);
      if (i < 2) chk("message", rd, 32'hC0DE0000 + i);
    end
  endtask
  task automatic t_send;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, `PHRH_OFF_TX_VDM, 32'hA5000000 + s);
      req(8'h4, 8'h3, 16'(s), 16'h4, s == 3);
      // Word, destination and port are judged apart so no bit is lost to truncation.
      if (s < 3) chk("sent word", last_word, 32'hA5000000 + s);
      if (s < 3) chk("sent sop", {30'h0, last_sop}, s);
      if (s < 3) chk("sent port", {30'h0, last_port}, 32'h2);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_mode(1'b0);
    t_mode(1'b1);
    t_feature();
    t_objects();
    t_get();
    t_send();
    complete_run();
  end
endmodule // phrh_request_handler_test
`default_nettype wire
